// ---- hw/cpm_power_mode.sv ----
// Power mode controller: idle and stop states of the core, APB register slave.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - Idle bit write halts core after instruction
// R2 - Idle keeps registers and memory unchanged
// R3 - Idle never gates peripheral clocks
// R4 - Enabled interrupt or reset ends idle
// R5 - Interrupt wake clears idle, services interrupt
// R6 - Resume at instruction after idle write
// R7 - Reset ends idle, fetch from zero
// R8 - Watchdog keeps counting, resets out of idle
// R9 - Stop bit write enters stop after instruction
// R10 - Stop halts oscillator, core, digital peripherals
// R11 - Stop silences interrupts and timers except detector
// R12 - Stop leaves analog peripherals as selected
// R13 - Only reset ends stop, interrupts ignored
// R14 - Enabled clock detector resets out of stop
// R15 - Software disables detector for long stops
// R16 - Select bits read zero, reserved bits zero
module cpm_power_mode (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [cpm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [cpm_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [cpm_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Core side
  input  wire logic                       instrDone,
  input  wire logic                       irqPending,
  input  wire logic                       wdtEnable,
  input  wire logic                       mcdEnable,
  input  wire logic                       mcdTimeout,
  output logic                            coreHalt,
  output logic                            coreClkEn,
  output logic                            periphClkEn,
  output logic                            intOscEn,
  output logic                            irqTimerEn,
  output logic                            mcdActive,
  output logic                            internalReset,
  output logic      [15:0]                fetchAddr
);
  import cpm_pkg::*;

  // ************************************************************
  // Register access
  // ************************************************************
  logic [7:0]  pwrCtrl_r;
  logic        idleReq_r;
  logic        stopReq_r;
  cpm_state_t  state_r;
  cpm_state_t  state_nxt;
  logic        wakeIrq_r;
  logic        access;
  logic        hitCtrl;
  logic        hitStat;

  assign access  = psel && penable;
  assign hitCtrl = (paddr == PWR_CTRL_ADDR);
  assign hitStat = (paddr == STATUS_ADDR);
  assign pready  = 1'b1;
  assign pslverr = access && !hitCtrl && !hitStat;

  // Select bits are write-only triggers; the reserved upper bits stay zero.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pwrCtrl_r <= PWR_CTRL_RESET; // [R16]
      idleReq_r <= 1'b0;
      stopReq_r <= 1'b0;
    end else begin
      if (access && pwrite && hitCtrl && pstrb[0]) begin
        idleReq_r <= pwdata[IDLE_BIT]; // [R1]
        stopReq_r <= pwdata[STOP_BIT]; // [R9]
      end else if (instrDone) begin
        idleReq_r <= 1'b0;
        stopReq_r <= 1'b0;
      end
      pwrCtrl_r <= PWR_CTRL_RESET; // [R16]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == PWR_CTRL_ADDR) begin
        prdata <= {24'h000000, pwrCtrl_r}; // [R16]
      end else if (paddr == STATUS_ADDR) begin
        prdata <= {28'h0000000, wakeIrq_r, state_r == CPM_STOP,
                   state_r == CPM_IDLE, state_r == CPM_RUN};
      end else begin
        prdata <= '0;
      end
    end
  end

  // ************************************************************
  // Power state machine
  // ************************************************************
  // Stop has no interrupt exit at all; only the synchronous reset leaves it.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CPM_RUN: begin
        if (instrDone && stopReq_r) begin
          state_nxt = CPM_STOP; // [R9]
        end else if (instrDone && idleReq_r) begin
          state_nxt = CPM_IDLE; // [R1]
        end
      end
      CPM_IDLE: begin
        if (irqPending) begin
          state_nxt = CPM_RUN; // [R4] [R5]
        end
      end
      CPM_STOP: begin
        state_nxt = CPM_STOP; // [R13]
      end
      default: state_nxt = CPM_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_r <= CPM_RUN; // [R7]
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wakeIrq_r <= 1'b0;
    end else if (state_r == CPM_IDLE && irqPending) begin
      wakeIrq_r <= 1'b1; // [R5] [R6]
    end else if (access && pwrite && hitStat) begin
      wakeIrq_r <= 1'b0;
    end
  end

  // ************************************************************
  // Outputs to the core and clock tree
  // ************************************************************
  // Halting the core clock freezes its registers, so the core resumes at the
  // next instruction when the halt drops.
  assign coreHalt    = (state_r != CPM_RUN); // [R1] [R2] [R6]
  assign coreClkEn   = (state_r == CPM_RUN); // [R2]
  assign periphClkEn = (state_r != CPM_STOP); // [R3] [R10]
  assign intOscEn    = (state_r != CPM_STOP); // [R10] [R12]
  assign irqTimerEn  = (state_r != CPM_STOP); // [R11]
  assign mcdActive   = mcdEnable; // [R11]
  assign fetchAddr   = RESET_VECTOR; // [R7]

  // A detector timeout raises the internal reset in idle with the watchdog enabled and in stop with the detector enabled.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      internalReset <= 1'b0;
    end else begin
      internalReset <= (wdtEnable && state_r == CPM_IDLE && mcdTimeout) // [R8]
                     || (mcdEnable && mcdTimeout && state_r == CPM_STOP); // [R14] [R15]
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_idle_enter;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_RUN && instrDone && idleReq_r && !stopReq_r) |=> state_r == CPM_IDLE;
  endproperty
  a_idle_enter: assert property (p_idle_enter) else $error("idle not entered"); // [R1]

  property p_stop_enter;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_RUN && instrDone && stopReq_r) |=> state_r == CPM_STOP;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered"); // [R9]

  property p_idle_wake;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_IDLE && irqPending) |=> (state_r == CPM_RUN && !coreHalt);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed"); // [R4]

  property p_stop_hold;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_STOP) |=> (state_r == CPM_STOP);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left early"); // [R13]

  property p_stop_clocks;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_STOP) |-> (!intOscEn && !periphClkEn && !irqTimerEn);
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("stop clocks on"); // [R10]

  property p_idle_periph;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_IDLE) |-> (periphClkEn && !coreClkEn);
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("idle clocks wrong"); // [R3]

  property p_mcd_reset;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_STOP && mcdEnable && mcdTimeout) |=> internalReset;
  endproperty
  a_mcd_reset: assert property (p_mcd_reset) else $error("no detector reset"); // [R14]

  property p_read_zero;
    @(posedge ref_clk) disable iff (!resetn)
      (psel && !penable && !pwrite && hitCtrl) |=> (prdata == 32'h00000000);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("select bits read one"); // [R16]

  // ************************************************************
  // Further checks on state, clocks and the register port
  // ************************************************************
  property p_idle_core_off;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_IDLE) |-> (coreHalt && !coreClkEn);
  endproperty
  a_idle_core_off: assert property (p_idle_core_off) else $error("core clock on in idle"); // [R2]

  property p_idle_hold;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_IDLE && !irqPending) |=> (state_r == CPM_IDLE);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left without wake"); // [R4]

  property p_wake_flag;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_IDLE && irqPending) |=> wakeIrq_r;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake flag not set"); // [R5]

  property p_wake_sticky;
    @(posedge ref_clk) disable iff (!resetn)
      (wakeIrq_r && !(access && pwrite && hitStat)) |=> wakeIrq_r;
  endproperty
  a_wake_sticky: assert property (p_wake_sticky) else $error("wake flag lost"); // [R5]

  property p_reset_vector;
    @(posedge ref_clk) disable iff (!resetn)
      (fetchAddr == RESET_VECTOR);
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("wrong reset vector"); // [R7]

  property p_wdt_reset;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_IDLE && wdtEnable && mcdTimeout) |=> internalReset;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("no watchdog reset"); // [R8]

  property p_stop_core_off;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_STOP) |-> (coreHalt && !coreClkEn);
  endproperty
  a_stop_core_off: assert property (p_stop_core_off) else $error("core runs in stop"); // [R10]

  property p_mcd_live;
    @(posedge ref_clk) disable iff (!resetn)
      (mcdActive == mcdEnable);
  endproperty
  a_mcd_live: assert property (p_mcd_live) else $error("detector gated"); // [R11]

  property p_stop_irq_ignored;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_STOP && irqPending) |=> (state_r == CPM_STOP);
  endproperty
  a_stop_irq_ignored: assert property (p_stop_irq_ignored) else $error("interrupt left stop"); // [R13]

  property p_no_stray_reset;
    @(posedge ref_clk) disable iff (!resetn)
      !((state_r == CPM_IDLE && wdtEnable && mcdTimeout)
        || (state_r == CPM_STOP && mcdEnable && mcdTimeout)) |=> !internalReset;
  endproperty
  a_no_stray_reset: assert property (p_no_stray_reset) else $error("stray reset"); // [R14]

  property p_ctrl_zero;
    @(posedge ref_clk) disable iff (!resetn)
      (pwrCtrl_r == PWR_CTRL_RESET);
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control bits not zero"); // [R16]

  property p_run_clocks;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_RUN) |-> (coreClkEn && periphClkEn && intOscEn && irqTimerEn && !coreHalt);
  endproperty
  a_run_clocks: assert property (p_run_clocks) else $error("run clocks wrong"); // [R3]

  property p_bad_addr;
    @(posedge ref_clk) disable iff (!resetn)
      (access && !hitCtrl && !hitStat) |-> pslverr;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("no error on unmapped access");

  property p_ready;
    @(posedge ref_clk) disable iff (!resetn)
      pready;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");

  property p_req_clear;
    @(posedge ref_clk) disable iff (!resetn)
      (instrDone && !(access && pwrite && hitCtrl)) |=> (!idleReq_r && !stopReq_r);
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("request not consumed"); // [R1]

  property p_idle_regs_kept;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_IDLE && !psel) |=> $stable(prdata);
  endproperty
  a_idle_regs_kept: assert property (p_idle_regs_kept) else $error("data lost in idle"); // [R2]

  property p_stop_priority;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_RUN && instrDone && stopReq_r && idleReq_r) |=> (state_r == CPM_STOP);
  endproperty
  a_stop_priority: assert property (p_stop_priority) else $error("idle beat stop"); // [R9]

  property p_run_hold;
    @(posedge ref_clk) disable iff (!resetn)
      (state_r == CPM_RUN && !instrDone) |=> (state_r == CPM_RUN);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("halt before instruction end"); // [R1]

  property p_status_upper;
    @(posedge ref_clk) disable iff (!resetn)
      (psel && !penable && !pwrite && hitStat) |=> (prdata[31:4] == 28'h0000000);
  endproperty
  a_status_upper: assert property (p_status_upper) else $error("status upper bits set");

  c_idle: cover property (@(posedge ref_clk) state_r == CPM_IDLE ##1 state_r == CPM_RUN);
  c_wake: cover property (@(posedge ref_clk) wakeIrq_r);
  c_stop: cover property (@(posedge ref_clk) state_r == CPM_STOP);
  c_rst: cover property (@(posedge ref_clk) internalReset);
endmodule
`default_nettype wire

// ---- hw/cpm_pkg.sv ----
// Constants for the processor core power mode control block.
package cpm_pkg;
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned PWR_CTRL_INDEX  = 32'h87;
  localparam logic [11:0] PWR_CTRL_ADDR   = 12'h21C;
  localparam logic [11:0] STATUS_ADDR     = 12'h220;
  localparam logic [7:0]  PWR_CTRL_RESET  = 8'h00;
  localparam int unsigned IDLE_BIT        = 0;
  localparam int unsigned STOP_BIT        = 1;
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;
  localparam int unsigned MCD_TIMEOUT_US  = 100;
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned ST_RUN_BIT      = 0;
  localparam int unsigned ST_IDLE_BIT     = 1;
  localparam int unsigned ST_STOP_BIT     = 2;
  localparam int unsigned ST_WAKE_BIT     = 3;
  typedef enum logic [1:0] {
    CPM_RUN  = 2'b00,
    CPM_IDLE = 2'b01,
    CPM_STOP = 2'b10
  } cpm_state_t;
endpackage

// ---- verif/cpm_core_model.sv ----
// Core-side partner model: retires instructions while running, raises interrupts.
`timescale 1ns/1ps
`default_nettype none
module cpm_core_model (
  // Clock
  input  wire logic ref_clk,
  // Core status and stimulus
  input  wire logic coreHalt,
  input  wire logic irqReq,
  output logic      instrDone,
  output logic      irqPending
);
  // A halted core completes nothing, so a wake must come from outside the core.
  always_ff @(posedge ref_clk) begin
    instrDone <= !coreHalt;
  end
  assign irqPending = irqReq;
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking testbench for the power mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpm_pkg::*;
  logic        ref_clk = 0, rstTb = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, instrDone, irqPending, irqReq = 0;
  logic        wdtEnable = 0, mcdEnable = 0, mcdTimeout = 0, coreHalt, coreClkEn;
  logic        periphClkEn, intOscEn, irqTimerEn, mcdActive, internalReset;
  logic [15:0] fetchAddr;
  int          n_mismatch = 0, n_checks = 0;
  // An internal reset request is fed back as a system reset.
  wire         resetn = rstTb & !internalReset;
  always #12.5 ref_clk = ~ref_clk;
  cpm_power_mode cpm_power_mode_inst (.ref_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .instrDone, .irqPending,
    .wdtEnable, .mcdEnable, .mcdTimeout, .coreHalt, .coreClkEn, .periphClkEn,
    .intOscEn, .irqTimerEn, .mcdActive, .internalReset, .fetchAddr);
  cpm_core_model cpm_core_model_inst (.ref_clk, .coreHalt, .irqReq, .instrDone,
    .irqPending);
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    chk(pready, 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic waitHalt(input logic v);
    for (int i = 0; i < 30 && coreHalt !== v; i++) @(posedge ref_clk);
  endtask
  task automatic waitRst();
    for (int i = 0; i < 30 && internalReset !== 1'b1; i++) @(posedge ref_clk);
    chk(internalReset, 1);
    mcdTimeout <= 0;
    wdtEnable <= 0;
    waitHalt(0);
    chk(fetchAddr, RESET_VECTOR);
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    apb(0, PWR_CTRL_ADDR, 0);
    chk(rd, {24'h0, PWR_CTRL_RESET});
    apb(0, 12'h300, 0);
    chk(err, 1);
    chk(rd, 0);
    $display("test reset done");
  endtask
  task automatic t_idle();
    apb(1, PWR_CTRL_ADDR, 32'h1);
    waitHalt(1);
    chk({coreHalt, coreClkEn, periphClkEn, intOscEn}, 4'hB);
    apb(0, PWR_CTRL_ADDR, 0);
    chk(rd, 0);
    irqReq <= 1;
    waitHalt(0);
    chk(coreHalt, 0);
    irqReq <= 0;
    apb(0, STATUS_ADDR, 0);
    chk(rd[3:0], 4'h9);
    $display("test idle done");
  endtask
  task automatic t_stop();
    mcdEnable <= 0;
    apb(1, PWR_CTRL_ADDR, 32'h2);
    waitHalt(1);
    chk({periphClkEn, intOscEn, irqTimerEn, coreClkEn}, 0);
    irqReq <= 1;
    repeat (10) @(posedge ref_clk);
    chk(coreHalt, 1);
    irqReq <= 0;
    mcdEnable <= 1;
    mcdTimeout <= 1;
    @(posedge ref_clk);
    chk(mcdActive, 1);
    waitRst();
    $display("test stop done");
  endtask
  task automatic t_wdt();
    wdtEnable <= 1;
    apb(1, PWR_CTRL_ADDR, 32'h1);
    waitHalt(1);
    mcdTimeout <= 1;
    waitRst();
    $display("test watchdog done");
  endtask
  initial begin
    #(25 * 4000);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rstTb <= 1;
    t_reset();
    t_idle();
    t_stop();
    t_wdt();
    end_of_test();
  end
endmodule
`default_nettype wire
